// ===== core/ssw_soft_switch.sv
/*
 * Soft switch function block: a gate input and a software-confirmed switch
 * value drive one binary output, latched or as a one-cycle pulse.
 * Assumes each CLK edge is one program cycle, EN_IN is synchronous to CLK,
 * and a single AHB-Lite master drives the register port.
 * There is no interrupt logic and no error response: every transfer is OKAY.
 * Power loss is modelled by stopping the program; SYS_RST is a full power-on.
 */
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module ssw_soft_switch (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        EN_IN,
    output logic             Q_OUT
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    ssw_pkg::ssw_bus_state_t bus_state;
    logic [7:0]              bus_addr;
    logic                    accept;
    logic                    wr_now;
    logic                    wr_ctrl;
    logic                    wr_switch;
    logic [31:0]             read_mux;

    ssw_pkg::ssw_ctrl_t      ctrl;
    logic                    switch_on;
    logic                    q;
    logic                    q_kept;
    logic                    kept_valid;
    logic                    en_prev;
    logic                    run_prev;

    // HSIZE is not decoded: only whole-word transfers are used.
    assign accept    = HSEL && HTRANS == ssw_pkg::HTRANS_NONSEQ && HREADY;
    assign wr_now    = bus_state == ssw_pkg::SSW_BUS_WRITE;
    assign wr_ctrl   = wr_now && bus_addr == ssw_pkg::ADDR_CTRL;
    assign wr_switch = wr_now && bus_addr == ssw_pkg::ADDR_SWITCH;

    // The bus state tracks the data phase of the transfer last taken.
    // A new address phase may be taken in any state once the bus is ready.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bus_state <= ssw_pkg::SSW_BUS_IDLE;
        end else begin
            case (bus_state)
                ssw_pkg::SSW_BUS_IDLE: begin
                    if (accept) begin
                        bus_state <= HWRITE ? ssw_pkg::SSW_BUS_WRITE : ssw_pkg::SSW_BUS_READ;
                    end
                end
                ssw_pkg::SSW_BUS_WRITE: begin
                    if (accept) begin
                        bus_state <= HWRITE ? ssw_pkg::SSW_BUS_WRITE : ssw_pkg::SSW_BUS_READ;
                    end else begin
                        bus_state <= ssw_pkg::SSW_BUS_IDLE;
                    end
                end
                ssw_pkg::SSW_BUS_READ: begin
                    if (accept) begin
                        bus_state <= HWRITE ? ssw_pkg::SSW_BUS_WRITE : ssw_pkg::SSW_BUS_READ;
                    end else if (HREADYOUT) begin
                        bus_state <= ssw_pkg::SSW_BUS_IDLE;
                    end
                end
                default: begin
                    bus_state <= ssw_pkg::SSW_BUS_IDLE;
                end
            endcase
        end
    end

    // The address is kept for the whole data phase.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bus_addr <= 8'h00;
        end else begin
            if (accept) begin
                bus_addr <= HADDR[7:0];
            end
        end
    end

    // Reads take one wait state so that the data register is loaded from
    // state that already includes a write made in the previous data phase.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            HREADYOUT <= 1'b1;
        end else begin
            if (accept && !HWRITE) begin
                HREADYOUT <= 1'b0;
            end else begin
                HREADYOUT <= 1'b1;
            end
        end
    end

    // Every transfer is answered OKAY; there is no error case.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            HRESP <= ssw_pkg::HRESP_OKAY;
        end else begin
            HRESP <= ssw_pkg::HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // Register read path
    // ----------------------------------------------------------------
    // Unmapped offsets and unused bits read as zero.
    always_comb begin
        read_mux = 32'h0000_0000;
        case (bus_addr)
            ssw_pkg::ADDR_CTRL: begin
                read_mux[ssw_pkg::CTRL_MOMENTARY_BIT] = ctrl.momentary;
                read_mux[ssw_pkg::CTRL_START_ON_BIT]  = ctrl.start_on;
                read_mux[ssw_pkg::CTRL_RETAIN_BIT]    = ctrl.retain;
                read_mux[ssw_pkg::CTRL_RUN_BIT]       = ctrl.run;
            end
            ssw_pkg::ADDR_SWITCH: begin
                read_mux[ssw_pkg::SWITCH_ON_BIT] = switch_on;
            end
            ssw_pkg::ADDR_STATUS: begin
                read_mux[ssw_pkg::STAT_Q_BIT]      = q;
                read_mux[ssw_pkg::STAT_GATE_BIT]   = en_prev;
                read_mux[ssw_pkg::STAT_SWITCH_BIT] = switch_on;
                read_mux[ssw_pkg::STAT_KEPT_BIT]   = q_kept;
                read_mux[ssw_pkg::STAT_KEPT_VALID] = kept_valid;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured in the wait cycle and held until the next read.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            HRDATA <= 32'h0000_0000;
        end else begin
            if (bus_state == ssw_pkg::SSW_BUS_READ && !HREADYOUT) begin
                HRDATA <= read_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration and switch value
    // ----------------------------------------------------------------
    // Configuration changes only in a write data phase.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl <= ssw_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl.momentary <= HWDATA[ssw_pkg::CTRL_MOMENTARY_BIT];
                ctrl.start_on  <= HWDATA[ssw_pkg::CTRL_START_ON_BIT];
                ctrl.retain    <= HWDATA[ssw_pkg::CTRL_RETAIN_BIT];
                ctrl.run       <= HWDATA[ssw_pkg::CTRL_RUN_BIT];
            end
        end
    end

    // A write to the switch register is the confirmation of a new value.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            switch_on <= ssw_pkg::SWITCH_RESET;
        end else begin
            if (wr_switch) begin
                switch_on <= HWDATA[ssw_pkg::SWITCH_ON_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Program cycle evaluation
    // ----------------------------------------------------------------
    logic en_rise;
    logic en_fall;
    logic off_confirm;
    logic run_start;

    // An edge is seen at the clock on which the new level is first sampled.
    assign en_rise     = EN_IN && !en_prev;
    assign en_fall     = !EN_IN && en_prev;
    assign off_confirm = wr_switch && !HWDATA[ssw_pkg::SWITCH_ON_BIT];
    assign run_start   = ctrl.run && !run_prev;

    // The previous gate sample starts low, the idle level of the gate, so
    // that no false edge follows reset.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            en_prev <= 1'b0;
        end else begin
            en_prev <= EN_IN;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            run_prev <= 1'b0;
        end else begin
            run_prev <= ctrl.run;
        end
    end

    // ----------------------------------------------------------------
    // Output state
    // ----------------------------------------------------------------
    // Clearing causes take priority over a gate-rise set in the same cycle; a program start outranks all but a stop.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q <= 1'b0;
        end else begin
            if (!ctrl.run) begin
                q <= 1'b0;
            end else if (run_start) begin
                if (ctrl.retain && kept_valid) begin
                    q <= q_kept;
                end else begin
                    q <= ctrl.start_on;
                end
            end else if (en_fall) begin
                q <= 1'b0;
            end else if (off_confirm) begin
                q <= 1'b0;
            end else if (ctrl.momentary && q) begin
                q <= 1'b0;
            end else if (en_rise && switch_on) begin
                q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Retained copy
    // ----------------------------------------------------------------
    // Copy of the output kept while the program runs; stopping the program
    // stands for a power loss and the copy survives it.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q_kept <= 1'b0;
        end else begin
            if (ctrl.run && !run_start) begin
                q_kept <= q;
            end
        end
    end

    // The copy becomes valid once one running cycle has been captured.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            kept_valid <= 1'b0;
        end else begin
            if (ctrl.run && !run_start) begin
                kept_valid <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output register
    // ----------------------------------------------------------------
    // The port copy adds one cycle so that the pin comes from a flip-flop.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            Q_OUT <= 1'b0;
        end else begin
            Q_OUT <= q;
        end
    end

endmodule

`default_nettype wire

// ===== core/ssw_pkg.sv
/*
 * Shared constants and types for the soft switch function block.
 * Assumes a 32-bit AHB-Lite register bus and one program cycle per clock.
 */
package ssw_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SWITCH = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MOMENTARY_BIT = 0;
    localparam int CTRL_START_ON_BIT  = 1;
    localparam int CTRL_RETAIN_BIT    = 2;
    localparam int CTRL_RUN_BIT       = 3;
    localparam int SWITCH_ON_BIT      = 0;
    localparam int STAT_Q_BIT         = 0;
    localparam int STAT_GATE_BIT      = 1;
    localparam int STAT_SWITCH_BIT    = 2;
    localparam int STAT_KEPT_BIT      = 3;
    localparam int STAT_KEPT_VALID    = 4;

    // ----------------------------------------------------------------
    // Bus encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;
    localparam logic       SWITCH_RESET  = 1'b0;

    typedef struct packed {
        logic run;
        logic retain;
        logic start_on;
        logic momentary;
    } ssw_ctrl_t;

    // Switching action, start off, no retention, program stopped.
    localparam ssw_ctrl_t CTRL_RESET = '{run: 1'b0, retain: 1'b0, start_on: 1'b0, momentary: 1'b0};

    typedef enum logic [1:0] {
        SSW_BUS_IDLE  = 2'b00,
        SSW_BUS_WRITE = 2'b01,
        SSW_BUS_READ  = 2'b10
    } ssw_bus_state_t;

endpackage

// ===== testbench/ssw_chk_sva.sv
/* Port checker for the soft switch block.
 * Assumes one bus master and HREADY tied to HREADYOUT. */
`timescale 1ns/1ps
`default_nettype none
module ssw_chk (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        EN_IN,
    input wire logic        Q_OUT
);
    logic               a_wr;
    logic [7:0]         a_ad;
    logic               sw;
    ssw_pkg::ssw_ctrl_t ctl;
    logic               wr_sw;
    logic               wr_ct;
    assign wr_sw = a_wr && (a_ad == ssw_pkg::ADDR_SWITCH);
    assign wr_ct = a_wr && (a_ad == ssw_pkg::ADDR_CTRL);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Shadow copies of the control and switch registers, taken at write data phases.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            a_wr <= 1'b0;
            a_ad <= 8'h00;
            sw   <= ssw_pkg::SWITCH_RESET;
            ctl  <= ssw_pkg::CTRL_RESET;
        end else begin
            if (HREADY) begin
                a_wr <= HSEL && (HTRANS == ssw_pkg::HTRANS_NONSEQ) && HWRITE;
                a_ad <= HADDR[7:0];
            end
            if (wr_sw) sw <= HWDATA[0];
            if (wr_ct) ctl <= ssw_pkg::ssw_ctrl_t'(HWDATA[3:0]);
        end
    end
    set_on_a: assert property (ctl.run && sw && $rose(EN_IN) && !a_wr && !$past(wr_ct) |-> ##2 Q_OUT)
        else $error("output not set by gate rise");
    fall_clr_a: assert property ($fell(EN_IN) && !$past(wr_ct) |-> ##2 !Q_OUT)
        else $error("output not cleared by gate fall");
    pulse_one_a: assert property ($past(ctl.momentary) && $rose(Q_OUT) |=> !Q_OUT)
        else $error("momentary pulse longer than one cycle");
    hold_on_a: assert property (ctl.run && !ctl.momentary && EN_IN && $past(EN_IN) && !a_wr ##1 Q_OUT |=> Q_OUT)
        else $error("latched output dropped");
    off_clr_a: assert property (wr_sw && !HWDATA[0] && ctl.run && !$past(wr_ct) |-> ##2 !Q_OUT)
        else $error("off confirm did not clear");
    stop_clr_a: assert property (!ctl.run && !wr_ct |-> ##2 !Q_OUT)
        else $error("output high while stopped");
    start_val_a: assert property (wr_ct && !ctl.run && HWDATA[3] && !HWDATA[2]
        |-> ##3 Q_OUT == $past(HWDATA[1], 3))
        else $error("start state not applied");
    rise_only_a: assert property ($rose(Q_OUT) && !$past(wr_ct, 3) |-> $past(EN_IN, 2) && !$past(EN_IN, 3))
        else $error("output set without a gate rise");
    rst_quiet_a: assert property ($fell(SYS_RST) |-> !Q_OUT && HREADYOUT)
        else $error("outputs wrong after reset");
endmodule
`default_nettype wire

// ===== testbench/ssw_op.sv
/* Operator model: an AHB-Lite master setting and confirming parameters.
 * Assumes HREADY is the slave's HREADYOUT. */
`timescale 1ns/1ps
`default_nettype none
module ssw_op (
    input  wire logic        CLK,
    input  wire logic        HREADY,
    input  wire logic [31:0] HRDATA,
    output var  logic        HSEL,
    output var  logic [31:0] HADDR,
    output var  logic [1:0]  HTRANS,
    output var  logic        HWRITE,
    output var  logic [2:0]  HSIZE,
    output var  logic [31:0] HWDATA,
    output var  logic        hung
);
    initial begin
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
        hung = 1'b0;
    end
    task automatic wt();
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADY !== 1'b1 && n < 20);
        if (n >= 20) hung <= 1'b1;
    endtask
    // Every write is one confirmed setting; released data lines flip to the inverse.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge CLK);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        HTRANS <= ssw_pkg::HTRANS_NONSEQ;
        wt();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HADDR <= ~HADDR;
        if (w) HWDATA <= d;
        wt();
        q = HRDATA;
        HWDATA <= ~HWDATA;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
/* Self-checking bench for the soft switch block.
 * Assumes the operator model and the port checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
    logic        CLK;
    logic        SYS_RST;
    logic        EN_IN;
    logic        HSEL;
    logic [31:0] HADDR;
    logic [1:0]  HTRANS;
    logic        HWRITE;
    logic [2:0]  HSIZE;
    logic [31:0] HWDATA;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    logic        Q_OUT;
    logic        hung;
    logic [31:0] rd;
    logic [2:0]  n;
    int          errors = 0;
    int          tests_run = 0;
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    ssw_soft_switch i_ssw_soft_switch (.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EN_IN(EN_IN), .Q_OUT(Q_OUT));
    ssw_op i_ssw_op (.CLK(CLK), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .hung(hung));
    task automatic end_sim();
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge CLK) if (hung === 1'b1) begin
        errors++;
        end_sim();
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_ssw_op.xfer(1'b1, a, d, rd);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        i_ssw_op.xfer(1'b0, a, 32'h0, rd);
        `CHK(nm, e, rd)
    endtask
    task automatic en(input logic v);
        @(posedge CLK);
        EN_IN <= v;
    endtask
    task automatic qchk(input int c, input logic e);
        repeat (c) @(posedge CLK);
        `CHK("q_out", e, Q_OUT)
    endtask
    task automatic t_reset();
        rchk("ctrl", ssw_pkg::ADDR_CTRL, 32'h0);
        rchk("switch", ssw_pkg::ADDR_SWITCH, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        qchk(0, 1'b0);
        `CHK("hresp", 1'b0, HRESP)
    endtask
    task automatic t_switch();
        wr(ssw_pkg::ADDR_CTRL, 32'h8);
        wr(ssw_pkg::ADDR_SWITCH, 32'h1);
        rchk("switch", ssw_pkg::ADDR_SWITCH, 32'h1);
        en(1'b1);
        qchk(3, 1'b1);
        qchk(4, 1'b1);
        rchk("status", ssw_pkg::ADDR_STATUS, 32'h1f);
        en(1'b0);
        qchk(3, 1'b0);
        en(1'b1);
        qchk(3, 1'b1);
        wr(ssw_pkg::ADDR_SWITCH, 32'h0);
        qchk(2, 1'b0);
        en(1'b0);
        en(1'b1);
        qchk(3, 1'b0);
    endtask
    task automatic t_mom();
        wr(ssw_pkg::ADDR_CTRL, 32'h9);
        wr(ssw_pkg::ADDR_SWITCH, 32'h1);
        en(1'b0);
        en(1'b1);
        n = 3'd0;
        repeat (6) begin
            @(posedge CLK);
            n = n + {2'b00, Q_OUT};
        end
        `CHK("pulse", 3'd1, n)
    endtask
    task automatic t_start();
        wr(ssw_pkg::ADDR_CTRL, 32'h0);
        qchk(3, 1'b0);
        wr(ssw_pkg::ADDR_CTRL, 32'ha);
        qchk(3, 1'b1);
        wr(ssw_pkg::ADDR_CTRL, 32'he);
        wr(ssw_pkg::ADDR_CTRL, 32'h0);
        wr(ssw_pkg::ADDR_CTRL, 32'hc);
        qchk(3, 1'b1);
        wr(ssw_pkg::ADDR_CTRL, 32'h0);
        wr(ssw_pkg::ADDR_CTRL, 32'h8);
        qchk(3, 1'b0);
    endtask
    initial begin
        SYS_RST = 1'b1;
        EN_IN = 1'b0;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_reset();
        t_switch();
        t_mom();
        t_start();
        end_sim();
    end
endmodule
bind ssw_soft_switch ssw_chk i_ssw_chk (.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .EN_IN(EN_IN), .Q_OUT(Q_OUT));
`default_nettype wire
